// ===== hdl/interlock_defines.vh
// Constants for the safety interlock and mode gate block.
// Assumes a 200 MHz reference clock and switch inputs already debounced outside.
`ifndef INTERLOCK_DEFINES_VH
`define INTERLOCK_DEFINES_VH
`define REG_CTRL 4'h0
`define REG_STAT 4'h1
`define REG_IRQ_STAT 4'h2
`define REG_IRQ_MASK 4'h3
`define CTRL_SERVO_REQ 0
`define CTRL_AUTO_RUN 1
`define CTRL_JOG_REQ 2
`define CTRL_BRAKE_REQ 3
`define CTRL_ALARM_RESET 4
`define CTRL_WIDTH 4
`define IRQ_DOOR_ERR 0
`define IRQ_SERVO_DROP 1
`define IRQ_ENABLE_LOST 2
`define IRQ_WIDTH 3
`define IRQ_MASK_RESET 3'h0
`define STAT_SERVO_ON 0
`define STAT_AUTO_RUN 1
`define STAT_DOOR_ERROR 2
`define STAT_DOOR_CLOSED 3
`define STAT_MODE_AUTO 4
`define STAT_PENDANT_EN 5
`define STAT_ENSW_LSB 6
`define STAT_ENSW_MSB 7
`define ENSW_RELEASED 2'h0
`define ENSW_LIGHT 2'h1
`define ENSW_FULL 2'h2
`endif

// ===== hdl/sync_2ff.v
// Two flip-flop synchroniser for a bundle of slow pin levels.
// Assumes inputs are static for several clocks around each change.
module sync_2ff #(
    parameter WIDTH = 1
) (
    input wire i_clk,
    input wire i_rst,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] stage;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stage <= {WIDTH{1'b0}};
            o_sync <= {WIDTH{1'b0}};
        end else begin
            stage <= i_async;
            o_sync <= stage;
        end
    end
endmodule // sync_2ff

// ===== hdl/reg_port.v
// Register port: address decode, write strobe and one-cycle-late read data.
// Assumes strobes are single cycle and never both at once.
`include "interlock_defines.vh"
module reg_port (
    input wire i_clk,
    input wire i_rst,
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [`IRQ_WIDTH-1:0] i_events,
    input wire [31:0] i_stat_word,
    output reg [31:0] o_rdata,
    output reg [`CTRL_WIDTH-1:0] o_ctrl,
    output reg o_alarm_reset,
    output reg [`IRQ_WIDTH-1:0] o_irq_stat,
    output reg [`IRQ_WIDTH-1:0] o_irq_mask
);
    wire wr_ctrl = i_wr && (i_addr == `REG_CTRL);
    wire wr_istat = i_wr && (i_addr == `REG_IRQ_STAT);
    wire wr_imask = i_wr && (i_addr == `REG_IRQ_MASK);
    reg [31:0] next_rdata;

    always @* begin
        case (i_addr)
            `REG_CTRL: next_rdata = {{(32-`CTRL_WIDTH){1'b0}}, o_ctrl};
            `REG_STAT: next_rdata = i_stat_word;
            `REG_IRQ_STAT: next_rdata = {{(32-`IRQ_WIDTH){1'b0}}, o_irq_stat};
            `REG_IRQ_MASK: next_rdata = {{(32-`IRQ_WIDTH){1'b0}}, o_irq_mask};
            default: next_rdata = 32'h0;
        endcase
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0;
            o_ctrl <= {`CTRL_WIDTH{1'b0}};
            o_alarm_reset <= 1'b0;
            o_irq_stat <= {`IRQ_WIDTH{1'b0}};
            o_irq_mask <= `IRQ_MASK_RESET;
        end else begin
            o_rdata <= i_rd ? next_rdata : 32'h0;
            o_alarm_reset <= wr_ctrl && i_wdata[`CTRL_ALARM_RESET];
            if (wr_ctrl)
                o_ctrl <= i_wdata[`CTRL_WIDTH-1:0];
            if (wr_imask)
                o_irq_mask <= i_wdata[`IRQ_WIDTH-1:0];
            // Set wins over write-one-to-clear
            o_irq_stat <= (o_irq_stat & ~(wr_istat ? i_wdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}})) | i_events;
        end
    end
endmodule // reg_port

// ===== hdl/safety_interlock_mode_gate.v
// Safety interlock and mode gate: decides servo, jog, brake and automatic permits.
// Assumes switch pins are asynchronous levels; registers reached over a plain port.
`include "interlock_defines.vh"
module safety_interlock_mode_gate (
    input wire I_REF_CLK,
    input wire I_RST,
    input wire I_DOOR_CLOSED,
    input wire I_MODE_AUTO,
    input wire I_PENDANT_ENABLED,
    input wire [1:0] I_ENABLE_SWITCH,
    input wire [3:0] I_ADDR,
    input wire [31:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output wire [31:0] O_RDATA,
    output reg O_SERVO_ON,
    output reg O_JOG_ALLOWED,
    output reg O_BRAKE_RELEASE,
    output reg O_AUTO_RUN,
    output reg O_DOOR_ERROR,
    output reg O_AXIS_SERVO_SYNC_CONTACT,
    output wire O_IRQ
);
    localparam ST_OFF = 3'b001;
    localparam ST_ON = 3'b010;
    localparam ST_FAULT = 3'b100;

    wire door_closed;
    wire mode_auto;
    wire pendant_en;
    wire [1:0] ensw;
    wire [`CTRL_WIDTH-1:0] ctrl;
    wire alarm_reset;
    wire [`IRQ_WIDTH-1:0] irq_stat;
    wire [`IRQ_WIDTH-1:0] irq_mask;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [`IRQ_WIDTH-1:0] events;
    reg manual;
    reg light_grip;
    reg manual_ok;
    reg auto_ok;
    reg servo_allowed;
    reg door_trip;
    reg grip_lost;
    reg [31:0] stat_word;
    reg next_servo_on;
    reg next_sync_contact;
    reg next_door_error;
    reg next_jog_allowed;
    reg next_brake_release;
    reg next_auto_run;

    // Only the light press of the enable switch lets the arm move
    function grip_is_light;
        input [1:0] pos;
        begin
            case (pos)
                `ENSW_LIGHT: grip_is_light = 1'b1;
                `ENSW_RELEASED: grip_is_light = 1'b0;
                `ENSW_FULL: grip_is_light = 1'b0;
                default: grip_is_light = 1'b0;
            endcase
        end
    endfunction

    function state_is_on;
        input [2:0] st;
        begin
            state_is_on = (st == ST_ON);
        end
    endfunction

    function manual_permit;
        input pendant;
        input auto_sel;
        input [1:0] pos;
        begin
            manual_permit = pendant && !auto_sel && grip_is_light(pos);
        end
    endfunction

    function auto_permit;
        input pendant;
        input auto_sel;
        input door;
        begin
            auto_permit = !pendant && auto_sel && door;
        end
    endfunction

    // Events raised when the servo leaves the on state
    function [`IRQ_WIDTH-1:0] drop_events;
        input tripped;
        input grip_gone;
        begin
            drop_events = {`IRQ_WIDTH{1'b0}};
            drop_events[`IRQ_SERVO_DROP] = 1'b1;
            drop_events[`IRQ_DOOR_ERR] = tripped;
            drop_events[`IRQ_ENABLE_LOST] = grip_gone;
        end
    endfunction

    // Each switch level passes two flops before any permit reads it
    sync_2ff #(.WIDTH(1)) u_sync_door (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_async(I_DOOR_CLOSED),
        .o_sync(door_closed)
    );

    sync_2ff #(.WIDTH(1)) u_sync_mode (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_async(I_MODE_AUTO),
        .o_sync(mode_auto)
    );

    sync_2ff #(.WIDTH(1)) u_sync_pendant (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_async(I_PENDANT_ENABLED),
        .o_sync(pendant_en)
    );

    sync_2ff #(.WIDTH(2)) u_sync_grip (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_async(I_ENABLE_SWITCH),
        .o_sync(ensw)
    );

    // Permits from the synchronised switch levels
    always @* begin
        manual = !mode_auto;
        light_grip = grip_is_light(ensw);
        manual_ok = manual_permit(pendant_en, mode_auto, ensw);
        auto_ok = auto_permit(pendant_en, mode_auto, door_closed);
        if (manual) begin
            servo_allowed = manual_ok;
        end else begin
            servo_allowed = auto_ok;
        end
    end

    // Trip conditions only count while the servo is on
    always @* begin
        if (mode_auto && !door_closed && state_is_on(state)) begin
            door_trip = 1'b1;
        end else begin
            door_trip = 1'b0;
        end
        if (manual && pendant_en && !light_grip && state_is_on(state)) begin
            grip_lost = 1'b1;
        end else begin
            grip_lost = 1'b0;
        end
    end

    // Status word for software
    always @* begin
        stat_word = 32'h0;
        stat_word[`STAT_SERVO_ON] = O_SERVO_ON;
        stat_word[`STAT_AUTO_RUN] = O_AUTO_RUN;
        stat_word[`STAT_DOOR_ERROR] = O_DOOR_ERROR;
        stat_word[`STAT_DOOR_CLOSED] = door_closed;
        stat_word[`STAT_MODE_AUTO] = mode_auto;
        stat_word[`STAT_PENDANT_EN] = pendant_en;
        stat_word[`STAT_ENSW_MSB:`STAT_ENSW_LSB] = ensw;
    end

    reg_port u_regs (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_addr(I_ADDR),
        .i_wdata(I_WDATA),
        .i_wr(I_WR),
        .i_rd(I_RD),
        .i_events(events),
        .i_stat_word(stat_word),
        .o_rdata(O_RDATA),
        .o_ctrl(ctrl),
        .o_alarm_reset(alarm_reset),
        .o_irq_stat(irq_stat),
        .o_irq_mask(irq_mask)
    );

    assign O_IRQ = |(irq_stat & irq_mask);

    // Servo state: off, on, latched door fault
    always @* begin
        next_state = state;
        events = {`IRQ_WIDTH{1'b0}};
        case (state)
            ST_OFF: begin
                // Servo-on only on request and while permitted
                if (ctrl[`CTRL_SERVO_REQ] && servo_allowed) begin
                    next_state = ST_ON;
                end
            end
            ST_ON: begin
                if (door_trip) begin
                    next_state = ST_FAULT;
                    events = drop_events(1'b1, 1'b0);
                end else if (!servo_allowed || !ctrl[`CTRL_SERVO_REQ]) begin
                    next_state = ST_OFF;
                    events = drop_events(1'b0, grip_lost);
                end
            end
            ST_FAULT: begin
                // Servo requests are refused until the alarm is reset with the door shut
                if (alarm_reset && door_closed) begin
                    next_state = ST_OFF;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    // Output values, except brake release, follow the state being entered
    always @* begin
        next_servo_on = 1'b0;
        next_sync_contact = 1'b0;
        next_door_error = 1'b0;
        next_jog_allowed = 1'b0;
        next_brake_release = 1'b0;
        next_auto_run = 1'b0;
        case (next_state)
            ST_ON: begin
                next_servo_on = 1'b1;
                next_sync_contact = 1'b1;
                next_jog_allowed = manual_ok && ctrl[`CTRL_JOG_REQ];
                next_auto_run = auto_ok && ctrl[`CTRL_AUTO_RUN];
            end
            ST_FAULT: begin
                next_door_error = 1'b1;
            end
            default: begin
                next_servo_on = 1'b0;
            end
        endcase
        // Brake release does not wait for servo-on
        next_brake_release = manual_ok && ctrl[`CTRL_BRAKE_REQ];
    end

    // State and registered outputs
    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_SERVO_ON <= 1'b0;
        end else begin
            O_SERVO_ON <= next_servo_on;
        end
    end

    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_AXIS_SERVO_SYNC_CONTACT <= 1'b0;
        end else begin
            O_AXIS_SERVO_SYNC_CONTACT <= next_sync_contact;
        end
    end

    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_DOOR_ERROR <= 1'b0;
        end else begin
            O_DOOR_ERROR <= next_door_error;
        end
    end

    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_JOG_ALLOWED <= 1'b0;
        end else begin
            O_JOG_ALLOWED <= next_jog_allowed;
        end
    end

    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_BRAKE_RELEASE <= 1'b0;
        end else begin
            O_BRAKE_RELEASE <= next_brake_release;
        end
    end

    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_AUTO_RUN <= 1'b0;
        end else begin
            O_AUTO_RUN <= next_auto_run;
        end
    end
endmodule // safety_interlock_mode_gate

// ===== verif/interlock_assertions.sv
// Checker for the permits, the door trip and the sync contact.
// Bound into the gate; sees the raw pin levels ahead of its synchroniser.
module interlock_assertions (
    input wire I_REF_CLK,
    input wire I_RST,
    input wire I_DOOR_CLOSED,
    input wire I_MODE_AUTO,
    input wire I_PENDANT_ENABLED,
    input wire [1:0] I_ENABLE_SWITCH,
    input wire O_SERVO_ON,
    input wire O_JOG_ALLOWED,
    input wire O_AUTO_RUN,
    input wire O_DOOR_ERROR,
    input wire O_AXIS_SERVO_SYNC_CONTACT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    wire man_ok = I_PENDANT_ENABLED & !I_MODE_AUTO & (I_ENABLE_SWITCH == 2'h1);
    wire auto_ok = !I_PENDANT_ENABLED & I_MODE_AUTO & I_DOOR_CLOSED;
    // Last four pin samples, covering the synchroniser lag
    reg [3:0] man_h, auto_h;
    always @(posedge I_REF_CLK) {man_h, auto_h} <= {man_h[2:0], man_ok, auto_h[2:0], auto_ok};
    sequence grip_gone;
        (!I_MODE_AUTO && I_ENABLE_SWITCH != 2'h1) [*6];
    endsequence
    jog_gate_a: assert property (O_JOG_ALLOWED |-> |man_h) else $error("jog gate");
    auto_gate_a: assert property (O_AUTO_RUN |-> |auto_h) else $error("auto gate");
    servo_gate_a: assert property (O_SERVO_ON |-> |man_h || |auto_h) else $error("servo gate");
    grip_cut_a: assert property (grip_gone |-> !O_SERVO_ON) else $error("grip cut");
    door_trip_a: assert property (O_AUTO_RUN && $fell(I_DOOR_CLOSED) |-> ##[2:5] O_DOOR_ERROR) else $error("trip");
    err_block_a: assert property (O_DOOR_ERROR |-> !O_SERVO_ON && !O_AUTO_RUN) else $error("error block");
    err_keep_a: assert property ($fell(O_DOOR_ERROR) |-> $past(I_DOOR_CLOSED, 3)) else $error("error keep");
    sync_follow_a: assert property (O_AXIS_SERVO_SYNC_CONTACT == O_SERVO_ON) else $error("sync contact");
endmodule // interlock_assertions
bind safety_interlock_mode_gate interlock_assertions chk (.*);

// ===== verif/cell_wiring.sv
// Customer side: fence door switch and additional-axis amplifier feed.
// Door state comes from the bench; contact level 1 means closed.
module cell_wiring (
    input wire door_open,
    input wire contact,
    output wire door_pin,
    output wire amp_power
);
    timeunit 1ns;
    timeprecision 1ps;
    assign door_pin = !door_open;
    assign amp_power = contact;
endmodule // cell_wiring

// ===== verif/tb_top.sv
// Bench for the interlock gate: register accesses and switch scenarios.
// Needs the gate, its bound checker and the cell wiring model.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_REF_CLK = 0, I_RST = 1, I_MODE_AUTO = 0, I_PENDANT_ENABLED = 1, I_WR = 0, I_RD = 0, door_open = 1;
    logic [1:0] I_ENABLE_SWITCH = 2'h1;
    logic [3:0] I_ADDR = 4'h0;
    logic [31:0] I_WDATA = 32'h0;
    wire [31:0] O_RDATA;
    wire I_DOOR_CLOSED, O_SERVO_ON, O_JOG_ALLOWED, O_BRAKE_RELEASE, O_AUTO_RUN, O_DOOR_ERROR, O_IRQ, amp_power;
    wire O_AXIS_SERVO_SYNC_CONTACT;
    int miscompares = 0, samples_checked = 0;
    wire [7:0] outs = {O_SERVO_ON, O_JOG_ALLOWED, O_BRAKE_RELEASE, O_AUTO_RUN, O_DOOR_ERROR,
        O_AXIS_SERVO_SYNC_CONTACT, amp_power, O_IRQ};
    safety_interlock_mode_gate dut (.*);
    cell_wiring partner (.door_open(door_open), .contact(O_AXIS_SERVO_SYNC_CONTACT), .door_pin(I_DOOR_CLOSED),
        .amp_power(amp_power));
    initial forever #2.5 I_REF_CLK = ~I_REF_CLK;
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge I_REF_CLK);
        {I_WR, I_RD, I_ADDR, I_WDATA} <= {w, !w, a, d};
        @(posedge I_REF_CLK);
        {I_WR, I_RD} <= 2'h0;
        #1;
        if (!w) ck("read data", d, O_RDATA);
    endtask
    // Pins {auto, pendant, door open, grip}, then settle past the sync lag
    task automatic so(input logic [4:0] p, input logic [7:0] e);
        @(posedge I_REF_CLK);
        {I_MODE_AUTO, I_PENDANT_ENABLED, door_open, I_ENABLE_SWITCH} <= p;
        repeat (6) @(posedge I_REF_CLK);
        #1;
        ck("outputs", {24'h0, e}, {24'h0, outs});
    endtask
    task automatic close_out;
        if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge I_REF_CLK);
        miscompares++;
        close_out;
    end
    initial begin
        repeat (5) @(posedge I_REF_CLK);
        I_RST <= 1'b0;
        bus(1'b1, 4'h0, 32'h5);
        so(5'h0D, 8'hC6);
        bus(1'b1, 4'h0, 32'h9);
        so(5'h0D, 8'hA6);
        for (int g = 0; g < 3; g += 2) begin
            so(5'h0C | 5'(g), 8'h00);
            so(5'h0D, 8'hA6);
        end
        bus(1'b1, 4'h0, 32'h0);
        so(5'h11, 8'h00);
        bus(1'b0, 4'h2, 32'h6);
        bus(1'b1, 4'h2, 32'h7);
        bus(1'b1, 4'h3, 32'h1);
        bus(1'b1, 4'h0, 32'h3);
        so(5'h11, 8'h96);
        so(5'h15, 8'h09);
        bus(1'b0, 4'h2, 32'h3);
        bus(1'b1, 4'h0, 32'h13);
        so(5'h15, 8'h09);
        bus(1'b1, 4'h3, 32'h0);
        so(5'h11, 8'h08);
        bus(1'b1, 4'h2, 32'h7);
        bus(1'b1, 4'h3, 32'h1);
        bus(1'b1, 4'h0, 32'h10);
        so(5'h11, 8'h00);
        bus(1'b1, 4'h0, 32'h3);
        so(5'h11, 8'h96);
        bus(1'b0, 4'h1, 32'h5B);
        bus(1'b0, 4'h0, 32'h3);
        bus(1'b0, 4'h3, 32'h1);
        bus(1'b0, 4'hF, 32'h0);
        close_out;
    end
endmodule // tb_top
